// >>> design/dual_aout_pkg.sv
`default_nettype none
package dual_aout_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ             = 40_000_000;
  localparam int unsigned MS_TIME_US         = 1000;
  localparam int unsigned MS_CYCLES_DEF      = (CLK_HZ / 1_000_000) * MS_TIME_US;
  localparam int unsigned DEF_BAUD           = 9600;
  localparam int unsigned CHAR_BITS          = 11;
  localparam int unsigned SILENCE_HALF_CHARS = 7;
  localparam longint unsigned SILENCE_CYCLES_LONG =
    (longint'(CLK_HZ) * CHAR_BITS * SILENCE_HALF_CHARS + 2 * DEF_BAUD - 1) / (2 * DEF_BAUD);
  localparam int unsigned SILENCE_CYCLES_DEF = int'(SILENCE_CYCLES_LONG);

  // Register offsets
  localparam logic [15:0] OFS_NODE_ADDRESS = 16'h9C41;
  localparam logic [15:0] OFS_SERIAL_SETUP = 16'h9C42;
  localparam logic [15:0] OFS_DELAYS       = 16'h9C43;
  localparam logic [15:0] OFS_VERSION      = 16'h9C61;
  localparam logic [15:0] OFS_SETPOINT_CH1 = 16'h9C71;
  localparam logic [15:0] OFS_SETPOINT_CH2 = 16'h9C72;
  localparam logic [15:0] OFS_SLEW_CH1     = 16'h9C81;
  localparam logic [15:0] OFS_SLEW_CH2     = 16'h9C82;
  localparam logic [15:0] OFS_READBACK_CH1 = 16'h9CA1;
  localparam logic [15:0] OFS_READBACK_CH2 = 16'h9CA2;
  localparam logic [15:0] OFS_DRIVEN_CH1   = 16'h9CB1;
  localparam logic [15:0] OFS_DRIVEN_CH2   = 16'h9CB2;

  // Reset values
  localparam logic [15:0] NODE_ADDRESS_RST = 16'h0001;
  localparam logic [15:0] SERIAL_SETUP_RST = 16'h0035;
  localparam logic [15:0] DELAYS_RST       = 16'h0003;
  localparam logic [4:0]  SLEW_RST         = 5'h00;
  localparam logic [15:0] SETPOINT_RST     = 16'h0000;

  // Field positions and limits
  localparam int unsigned REPLY_LSB        = 0;
  localparam int unsigned EOQ_LSB          = 8;
  localparam int unsigned SERIAL_CODE_LSB  = 0;
  localparam logic [15:0] NODE_ADDRESS_MIN = 16'h0001;
  localparam logic [15:0] NODE_ADDRESS_MAX = 16'h00DF;
  localparam logic [3:0]  SERIAL_CODE_MIN  = 4'h5;
  localparam logic [3:0]  SERIAL_CODE_MAX  = 4'h9;
  localparam logic [7:0]  REPLY_MS_MAX     = 8'h3F;
  localparam logic [7:0]  EOQ_MS_MAX       = 8'h30;
  localparam logic [4:0]  SLEW_CODE_MAX    = 5'h12;
  localparam int unsigned READBACK_LSB     = 8;

  // Slew rate: code 1 is 0.156 percent of span per second
  localparam int unsigned SLEW_FRAC_BITS     = 32;
  localparam longint unsigned SLEW_SPAN      = 65536;
  localparam longint unsigned SLEW_BASE_NUM  = 156;
  localparam longint unsigned SLEW_BASE_DEN  = 100_000;
  localparam longint unsigned SLEW_BASE_STEP =
    ((SLEW_SPAN * SLEW_BASE_NUM) << SLEW_FRAC_BITS) / (SLEW_BASE_DEN * CLK_HZ);

  typedef enum logic [1:0] {PH_IDLE, PH_GAP, PH_EOQ, PH_DONE} phase_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } reg_rsp_type;

  typedef struct packed {
    logic [15:0] pos;
    logic [31:0] frac;
  } slew_state_type;

  typedef struct packed {
    logic [15:0]       node_addr;
    logic [15:0]       serial;
    logic [15:0]       delays;
    logic [1:0][15:0]  setpoint;
    logic [1:0][4:0]   slew;
    logic [1:0][7:0]   adc;
    logic              nv_load;
    reg_rsp_type       rsp;
    phase_type         phase;
    logic [31:0]       sil_cnt;
    logic [31:0]       ms_pre;
    logic [7:0]        elapsed_ms;
    logic [7:0]        eoq_cnt;
    logic              frame_end;
    logic              reply_ok;
  } ctrl_state_type;

  localparam ctrl_state_type CTRL_RESET = '{
    node_addr: NODE_ADDRESS_RST,
    serial:    SERIAL_SETUP_RST,
    delays:    DELAYS_RST,
    setpoint:  {SETPOINT_RST, SETPOINT_RST},
    slew:      {SLEW_RST, SLEW_RST},
    nv_load:   1'b1,
    phase:     PH_IDLE,
    default:   '0
  };

endpackage
`default_nettype wire

// >>> design/slew_channel.sv
`timescale 1ns/1ps
`default_nettype none
module slew_channel
  import dual_aout_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] target_i,
  input  wire logic [4:0]  code_i,
  output logic      [15:0] value_o
);

  slew_state_type state_q;
  slew_state_type state_d;
  logic [47:0]    cur;
  logic [47:0]    tgt;
  logic [47:0]    step;

  always_comb begin
    cur     = {state_q.pos, state_q.frac};
    tgt     = {target_i, 32'h0000_0000};
    step    = 48'(SLEW_BASE_STEP) << 5'(code_i - 5'h01);
    state_d = state_q;
    if (code_i == 5'h00 || cur == tgt) begin
      {state_d.pos, state_d.frac} = tgt;
    end else if (cur < tgt) begin
      if (tgt - cur <= step) begin
        {state_d.pos, state_d.frac} = tgt;
      end else begin
        {state_d.pos, state_d.frac} = cur + step;
      end
    end else begin
      if (cur - tgt <= step) begin
        {state_d.pos, state_d.frac} = tgt;
      end else begin
        {state_d.pos, state_d.frac} = cur - step;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign value_o = state_q.pos;

endmodule
`default_nettype wire

// >>> design/dual_aout_regs.sv
// Summary of operation
// - Node address accepts 1 to DF, resets to 0x0001.
// - Serial setup accepts low-field codes 5 to 9, resets to 0x0035.
// - Delay low byte is reply delay in ms, max 63, default 3.
// - Reply is permitted only after reply delay since last query character.
// - Delay high byte is end-of-query delay in ms, max 48, default 0.
// - Frame completes after 3.5 character silence plus end-of-query delay.
// - Delay register accepts up to 0x303F, resets to 0x0003.
// - Version register reads a build-time constant.
// - Setpoint 0 is negative full scale, FFFF positive; reached after slewing.
// - Live slew code writable, effective at once, reloaded from storage on reset.
// - Code 0 steps at once; code 1 is 0.156 percent span/s, doubling per code.
// - Second channel slew behaves like the first, starting at zero.
// - Each channel reads back its actual output with 8-bit resolution.
// - Driven value register reports the present slewed converter value.
`timescale 1ns/1ps
`default_nettype none
module dual_aout_regs
  import dual_aout_pkg::*;
#(
  parameter logic [15:0] VERSION        = 16'h0100, // Arbitrary value
  parameter int unsigned MS_CYCLES      = MS_CYCLES_DEF,
  parameter int unsigned SILENCE_CYCLES = SILENCE_CYCLES_DEF
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire reg_req_type reg_req_i,
  input  wire logic [4:0]  nv_slew_ch1_i,
  input  wire logic [4:0]  nv_slew_ch2_i,
  input  wire logic [7:0]  adc_ch1_i,
  input  wire logic [7:0]  adc_ch2_i,
  input  wire logic        rx_char_i,
  output reg_rsp_type      reg_rsp_o,
  output logic      [15:0] node_address_o,
  output logic      [15:0] serial_setup_o,
  output logic      [15:0] dac_ch1_o,
  output logic      [15:0] dac_ch2_o,
  output logic             frame_end_o,
  output logic             reply_permit_o
);

  if (MS_CYCLES < 1) begin : g_ms_check
    $error("MS_CYCLES must be at least 1");
  end
  if (SILENCE_CYCLES < 1) begin : g_sil_check
    $error("SILENCE_CYCLES must be at least 1");
  end

  ctrl_state_type   state_q;
  ctrl_state_type   state_d;
  logic [1:0][15:0] driven;
  logic [16:0]      rd_hit;
  logic             wr_ok;
  logic             tick;
  logic [7:0]       reply_ms;
  logic [7:0]       eoq_ms;

  // Slewing converters, one per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    slew_channel u_slew (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .target_i  (state_q.setpoint[ch]),
      .code_i    (state_q.slew[ch]),
      .value_o   (driven[ch])
    );
  end

  function automatic logic [4:0] nv_code(input logic [4:0] code);
    nv_code = (code <= SLEW_CODE_MAX) ? code : SLEW_RST;
  endfunction

  function automatic logic [16:0] read_value(input logic [15:0] addr, input ctrl_state_type st,
                                             input logic [1:0][15:0] drv);
    case (addr)
      OFS_NODE_ADDRESS: read_value = {1'b1, st.node_addr};
      OFS_SERIAL_SETUP: read_value = {1'b1, st.serial};
      OFS_DELAYS:       read_value = {1'b1, st.delays};
      OFS_VERSION:      read_value = {1'b1, VERSION};
      OFS_SETPOINT_CH1: read_value = {1'b1, st.setpoint[0]};
      OFS_SETPOINT_CH2: read_value = {1'b1, st.setpoint[1]};
      OFS_SLEW_CH1:     read_value = {1'b1, 11'h000, st.slew[0]};
      OFS_SLEW_CH2:     read_value = {1'b1, 11'h000, st.slew[1]};
      OFS_READBACK_CH1: read_value = {1'b1, st.adc[0], 8'h00};
      OFS_READBACK_CH2: read_value = {1'b1, st.adc[1], 8'h00};
      OFS_DRIVEN_CH1:   read_value = {1'b1, drv[0]};
      OFS_DRIVEN_CH2:   read_value = {1'b1, drv[1]};
      default:          read_value = {1'b0, 16'h0000};
    endcase
  endfunction

  always_comb begin
    state_d           = state_q;
    state_d.rsp       = '0;
    state_d.frame_end = 1'b0;
    state_d.adc       = {adc_ch2_i, adc_ch1_i};
    reply_ms          = state_q.delays[REPLY_LSB +: 8];
    eoq_ms            = state_q.delays[EOQ_LSB +: 8];
    tick              = (state_q.ms_pre == MS_CYCLES - 1);
    rd_hit            = read_value(reg_req_i.addr, state_q, driven);
    wr_ok             = 1'b0;

    // Power-up slope taken from nonvolatile storage one cycle after release
    if (state_q.nv_load) begin
      state_d.slew[0] = nv_code(nv_slew_ch1_i);
      state_d.slew[1] = nv_code(nv_slew_ch2_i);
      state_d.nv_load = 1'b0;
    end

    // Register writes; out-of-range values are refused and leave the register as is
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        OFS_NODE_ADDRESS: begin
          wr_ok = reg_req_i.wdata >= NODE_ADDRESS_MIN && reg_req_i.wdata <= NODE_ADDRESS_MAX;
          if (wr_ok) begin
            state_d.node_addr = reg_req_i.wdata;
          end
        end
        OFS_SERIAL_SETUP: begin
          wr_ok = reg_req_i.wdata[SERIAL_CODE_LSB +: 4] >= SERIAL_CODE_MIN &&
                  reg_req_i.wdata[SERIAL_CODE_LSB +: 4] <= SERIAL_CODE_MAX;
          if (wr_ok) begin
            state_d.serial = reg_req_i.wdata;
          end
        end
        OFS_DELAYS: begin
          wr_ok = reg_req_i.wdata[REPLY_LSB +: 8] <= REPLY_MS_MAX &&
                  reg_req_i.wdata[EOQ_LSB +: 8] <= EOQ_MS_MAX;
          if (wr_ok) begin
            state_d.delays = reg_req_i.wdata;
          end
        end
        OFS_SETPOINT_CH1: begin
          wr_ok               = 1'b1;
          state_d.setpoint[0] = reg_req_i.wdata;
        end
        OFS_SETPOINT_CH2: begin
          wr_ok               = 1'b1;
          state_d.setpoint[1] = reg_req_i.wdata;
        end
        OFS_SLEW_CH1: begin
          wr_ok = reg_req_i.wdata <= {11'h000, SLEW_CODE_MAX};
          if (wr_ok) begin
            state_d.slew[0] = reg_req_i.wdata[4:0];
          end
        end
        OFS_SLEW_CH2: begin
          wr_ok = reg_req_i.wdata <= {11'h000, SLEW_CODE_MAX};
          if (wr_ok) begin
            state_d.slew[1] = reg_req_i.wdata[4:0];
          end
        end
        default: wr_ok = 1'b0;
      endcase
      state_d.rsp.ack = 1'b1;
      state_d.rsp.err = !wr_ok;
    end else if (reg_req_i.rd) begin
      state_d.rsp.ack   = 1'b1;
      state_d.rsp.err   = !rd_hit[16];
      state_d.rsp.rdata = rd_hit[15:0];
    end

    // Frame timing: silence, then end-of-query delay; reply delay counts from the last character
    if (rx_char_i) begin
      state_d.phase      = PH_GAP;
      state_d.sil_cnt    = 32'h0000_0000;
      state_d.ms_pre     = 32'h0000_0000;
      state_d.elapsed_ms = 8'h00;
      state_d.eoq_cnt    = 8'h00;
      state_d.reply_ok   = 1'b0;
    end else begin
      state_d.ms_pre = tick ? 32'h0000_0000 : state_q.ms_pre + 32'h0000_0001;
      if (tick && state_q.elapsed_ms != 8'hFF) begin
        state_d.elapsed_ms = state_q.elapsed_ms + 8'h01;
      end
      case (state_q.phase)
        PH_IDLE: state_d.phase = PH_IDLE;
        PH_GAP: begin
          if (state_q.sil_cnt >= SILENCE_CYCLES - 1) begin
            if (eoq_ms == 8'h00) begin
              state_d.phase     = PH_DONE;
              state_d.frame_end = 1'b1;
            end else begin
              state_d.phase   = PH_EOQ;
              state_d.eoq_cnt = 8'h00;
              state_d.sil_cnt = 32'h0000_0000;
            end
          end else begin
            state_d.sil_cnt = state_q.sil_cnt + 32'h0000_0001;
          end
        end
        PH_EOQ: begin
          // Own millisecond count from the end of silence, so the whole delay is added
          if (state_q.sil_cnt >= MS_CYCLES - 1) begin
            state_d.sil_cnt = 32'h0000_0000;
            if (state_q.eoq_cnt + 8'h01 >= eoq_ms) begin
              state_d.phase     = PH_DONE;
              state_d.frame_end = 1'b1;
            end else begin
              state_d.eoq_cnt = state_q.eoq_cnt + 8'h01;
            end
          end else begin
            state_d.sil_cnt = state_q.sil_cnt + 32'h0000_0001;
          end
        end
        PH_DONE: state_d.phase = PH_DONE;
        default: state_d.phase = PH_IDLE;
      endcase
      state_d.reply_ok = (state_q.phase == PH_DONE) && (state_q.elapsed_ms >= reply_ms);
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= CTRL_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rsp_o      = state_q.rsp;
  assign node_address_o = state_q.node_addr;
  assign serial_setup_o = state_q.serial;
  assign dac_ch1_o      = driven[0];
  assign dac_ch2_o      = driven[1];
  assign frame_end_o    = state_q.frame_end;
  assign reply_permit_o = state_q.reply_ok;

endmodule
`default_nettype wire

// >>> dv/dual_aout_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dual_aout_regs_properties
  import dual_aout_pkg::*;
#(
  parameter logic [15:0] VERSION        = 16'h0100,
  parameter int unsigned MS_CYCLES      = MS_CYCLES_DEF,
  parameter int unsigned SILENCE_CYCLES = SILENCE_CYCLES_DEF
) (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire reg_req_type reg_req_i,
  input wire logic [4:0]  nv_slew_ch1_i,
  input wire logic [4:0]  nv_slew_ch2_i,
  input wire logic [7:0]  adc_ch1_i,
  input wire logic [7:0]  adc_ch2_i,
  input wire logic        rx_char_i,
  input wire reg_rsp_type reg_rsp_o,
  input wire logic [15:0] node_address_o,
  input wire logic [15:0] serial_setup_o,
  input wire logic [15:0] dac_ch1_o,
  input wire logic [15:0] dac_ch2_o,
  input wire logic        frame_end_o,
  input wire logic        reply_permit_o
);
  logic [31:0] quiet_q;
  logic [15:0] sp_q;
  logic [15:0] wdat_q;
  logic        spw_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Quiet time since last character and mirror of the first setpoint
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      quiet_q <= '0;
      sp_q    <= '0;
      wdat_q  <= '0;
      spw_q   <= 1'b0;
    end else begin
      quiet_q <= rx_char_i ? 32'h0 : quiet_q + ((&quiet_q) ? 32'h0 : 32'h1);
      spw_q   <= reg_req_i.wr && reg_req_i.addr == OFS_SETPOINT_CH1;
      wdat_q  <= reg_req_i.wdata;
      sp_q    <= (spw_q && reg_rsp_o.ack && !reg_rsp_o.err) ? wdat_q : sp_q;
    end
  end
  sequence s_rd(logic [15:0] a);
    reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == a;
  endsequence
  sequence s_wr(logic [15:0] a);
    reg_req_i.wr && reg_req_i.addr == a;
  endsequence
  sequence s_refused;
    reg_rsp_o.ack && reg_rsp_o.err;
  endsequence
  AST_NODE_RANGE: assert property (node_address_o >= NODE_ADDRESS_MIN && node_address_o <= NODE_ADDRESS_MAX)
    else $error("node address out of range");
  AST_SERIAL_CODE: assert property (serial_setup_o[3:0] >= SERIAL_CODE_MIN && serial_setup_o[3:0] <= SERIAL_CODE_MAX)
    else $error("serial code out of range");
  AST_DELAY_REFUSE: assert property (s_wr(OFS_DELAYS) ##0
    (reg_req_i.wdata[7:0] > REPLY_MS_MAX || reg_req_i.wdata[15:8] > EOQ_MS_MAX) |=> s_refused)
    else $error("bad delay value accepted");
  AST_SLEW_REFUSE: assert property ((s_wr(OFS_SLEW_CH1) or s_wr(OFS_SLEW_CH2)) ##0
    reg_req_i.wdata > {11'h0, SLEW_CODE_MAX} |=> s_refused)
    else $error("bad slew code accepted");
  AST_VERSION_READ: assert property (s_rd(OFS_VERSION) |=>
    reg_rsp_o.ack && !reg_rsp_o.err && reg_rsp_o.rdata == VERSION)
    else $error("version read wrong");
  AST_READBACK: assert property (s_rd(OFS_READBACK_CH1) ##0 $stable(adc_ch1_i) |=>
    reg_rsp_o.ack && reg_rsp_o.rdata == {$past(adc_ch1_i), 8'h00})
    else $error("readback wrong");
  AST_PERMIT_DROP: assert property (rx_char_i |=> !reply_permit_o)
    else $error("reply permit kept after character");
  AST_FRAME_GAP: assert property (frame_end_o |-> (quiet_q >= SILENCE_CYCLES) ##1 !frame_end_o)
    else $error("frame end too early or too long");
  AST_RAMP_BOUND: assert property ($stable(sp_q) |-> (($past(dac_ch1_o) <= sp_q) ?
    (dac_ch1_o >= $past(dac_ch1_o) && dac_ch1_o <= sp_q) : (dac_ch1_o <= $past(dac_ch1_o) && dac_ch1_o >= sp_q)))
    else $error("output moved away from setpoint");
endmodule
bind dual_aout_regs dual_aout_regs_properties #(.VERSION(VERSION), .MS_CYCLES(MS_CYCLES),
  .SILENCE_CYCLES(SILENCE_CYCLES)) dual_aout_regs_properties_i (.*);
`default_nettype wire

// >>> dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import dual_aout_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire reg_rsp_type reg_rsp_i,
  output reg_req_type      reg_req_o,
  output logic             rx_char_o
);
  initial begin
    reg_req_o = '0;
    rx_char_o = 1'b0;
  end
  // One register access; gap idles the host first, released fields carry junk
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, input int gap,
                      output reg_rsp_type rsp);
    int n = 0;
    repeat (gap) @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    #1 reg_req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk_i);
    #1 reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    rsp = reg_rsp_i;
    while (rsp.ack !== 1'b1 && n < 4) begin
      @(posedge sys_clk_i);
      #1 rsp = reg_rsp_i;
      n++;
    end
  endtask
  task automatic char_pulse();
    @(posedge sys_clk_i);
    #1 rx_char_o = 1'b1;
    @(posedge sys_clk_i);
    #1 rx_char_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_dual_aout_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_aout_regs;
  import dual_aout_pkg::*;
  localparam int unsigned MS_T  = 8;
  localparam int unsigned SIL_T = 5;
  localparam logic [15:0] VER_T = 16'h0100; // Arbitrary value
  localparam logic [63:0] ROWS [12] = '{
    64'h9C41_0000_0001_0001, 64'h9C41_00E0_0001_0001, 64'h9C41_00DF_00DF_0000, 64'h9C42_0034_0035_0001,
    64'h9C42_003A_0035_0001, 64'h9C42_0039_0039_0000, 64'h9C43_0040_0003_0001, 64'h9C43_3100_0003_0001,
    64'h9C43_303F_303F_0000, 64'h9C81_0013_0003_0001, 64'h9C82_0012_0012_0000, 64'h9C82_0013_0012_0001};
  logic        clk, reset, rx_char, frame_end, permit;
  logic [7:0]  adc1, adc2;
  logic [15:0] node_addr, serial, dac1, dac2;
  reg_req_type req;
  reg_rsp_type rsp, r;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  dual_aout_regs #(.VERSION(VER_T), .MS_CYCLES(MS_T), .SILENCE_CYCLES(SIL_T)) dual_aout_regs_i (
    .sys_clk_i(clk), .reset_i(reset), .reg_req_i(req), .nv_slew_ch1_i(5'h03), .nv_slew_ch2_i(5'h13),
    .adc_ch1_i(adc1), .adc_ch2_i(adc2), .rx_char_i(rx_char), .reg_rsp_o(rsp), .node_address_o(node_addr),
    .serial_setup_o(serial), .dac_ch1_o(dac1), .dac_ch2_o(dac2), .frame_end_o(frame_end),
    .reply_permit_o(permit));
  host_model host_model_i (.sys_clk_i(clk), .reg_rsp_i(rsp), .reg_req_o(req), .rx_char_o(rx_char));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
    host_model_i.xfer(1'b1, a, d, 0, r);
    check("write response", {14'h0, r.ack, r.err}, {14'h0, 1'b1, e});
  endtask
  task automatic rd(input logic [15:0] a, input logic e, input logic [15:0] x);
    host_model_i.xfer(1'b0, a, 16'h0, 1, r);
    check("read response", {14'h0, r.ack, r.err}, {14'h0, 1'b1, e});
    check("read data", r.rdata, x);
  endtask
  task automatic tick(inout int k);
    @(posedge clk);
    #1 k++;
  endtask
  task automatic t_defaults;
    rd(OFS_NODE_ADDRESS, 1'b0, 16'h0001);
    rd(OFS_SERIAL_SETUP, 1'b0, 16'h0035);
    rd(OFS_DELAYS, 1'b0, 16'h0003);
    rd(OFS_VERSION, 1'b0, VER_T);
    wr(OFS_VERSION, 16'h1234, 1'b1);
    rd(OFS_VERSION, 1'b0, VER_T);
    rd(OFS_SLEW_CH1, 1'b0, 16'h0003);
    rd(OFS_SLEW_CH2, 1'b0, 16'h0000);
    rd(16'h9C44, 1'b1, 16'h0000);
    check("node out", node_addr, 16'h0001);
    $display("defaults test done");
  endtask
  task automatic t_ranges;
    foreach (ROWS[i]) begin
      wr(ROWS[i][63:48], ROWS[i][47:32], ROWS[i][0]);
      rd(ROWS[i][63:48], 1'b0, ROWS[i][31:16]);
    end
    check("node out", node_addr, 16'h00DF);
    check("serial out", serial, 16'h0039);
    $display("ranges test done");
  endtask
  task automatic t_slew;
    int want;
    want = $rtoi(64.0 / (65536.0 * 0.00156 * 131072.0 / 40.0e6));
    wr(OFS_SLEW_CH1, 16'h0000, 1'b0);
    wr(OFS_SETPOINT_CH1, 16'hFFFF, 1'b0);
    tick(n);
    check("step high", dac1, 16'hFFFF);
    rd(OFS_DRIVEN_CH1, 1'b0, 16'hFFFF);
    wr(OFS_SETPOINT_CH1, 16'h0000, 1'b0);
    tick(n);
    check("step low", dac1, 16'h0000);
    wr(OFS_SETPOINT_CH2, 16'h0040, 1'b0);
    n = 0;
    check("ramp started", {15'h0, dac2 == 16'h0040}, 16'h0000);
    while (dac2 !== 16'h0040 && n < 2000) tick(n);
    check("ramp time", {15'h0, n >= want - 3 && n <= want + 3}, 16'h0001);
    repeat (20) tick(n);
    check("ramp end", dac2, 16'h0040);
    wr(OFS_SETPOINT_CH2, 16'h0100, 1'b0);
    repeat (10) tick(n);
    check("mid ramp", {15'h0, dac2 < 16'h0100}, 16'h0001);
    wr(OFS_SLEW_CH2, 16'h0000, 1'b0);
    tick(n);
    check("code change", dac2, 16'h0100);
    $display("slew test done");
  endtask
  task automatic t_readback;
    rd(OFS_READBACK_CH1, 1'b0, 16'h5A00);
    rd(OFS_READBACK_CH2, 1'b0, 16'hA500);
    adc1 = 8'hC3;
    rd(OFS_READBACK_CH1, 1'b0, 16'hC300);
    wr(OFS_READBACK_CH1, 16'h1111, 1'b1);
    $display("readback test done");
  endtask
  task automatic t_link;
    wr(OFS_DELAYS, 16'h0002, 1'b0);
    host_model_i.char_pulse();
    repeat (2) tick(n);
    host_model_i.char_pulse();
    n = 0;
    while (frame_end !== 1'b1 && n < 100) tick(n);
    check("silence", n[15:0], SIL_T[15:0]);
    while (permit !== 1'b1 && n < 200) tick(n);
    check("reply wait", {15'h0, n >= 2 * MS_T && n <= 2 * MS_T + 3}, 16'h0001);
    host_model_i.char_pulse();
    check("permit drop", {15'h0, permit}, 16'h0000);
    repeat (40) tick(n);
    wr(OFS_DELAYS, 16'h0100, 1'b0);
    host_model_i.char_pulse();
    n = 0;
    while (frame_end !== 1'b1 && n < 100) tick(n);
    check("query delay", n[15:0], 16'(SIL_T + MS_T));
    $display("link test done");
  endtask
  task automatic t_reset;
    @(posedge clk);
    #1 reset = 1'b1;
    @(posedge clk);
    #1 check("reset node", node_addr, 16'h0001);
    check("reset serial", serial, 16'h0035);
    check("reset permit", {15'h0, permit}, 16'h0000);
    @(posedge clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge clk);
    rd(OFS_SLEW_CH1, 1'b0, 16'h0003);
    rd(OFS_SLEW_CH2, 1'b0, 16'h0000);
    rd(OFS_DELAYS, 1'b0, 16'h0003);
    $display("reset test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    reset = 1'b1;
    adc1 = 8'h5A;
    adc2 = 8'hA5;
    repeat (3) @(posedge clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge clk);
    t_defaults();
    t_ranges();
    t_slew();
    t_readback();
    t_link();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
